// ### bench/pwf_pin_model.sv
// Purpose: Pin electronics stand-in: loops the drive back, else shows a bench level.
// Assumes: Ideal driver and comparators, no propagation delay.
// Notes: Level code 0 low, 1 high, 2 midband; a driven pin wins over the bench level.
`timescale 1ns/1ns
module pwf_pin_model (
  // Drive side
  input wire logic [3:0] drive_level,
  input wire logic [3:0] drive_on,
  // Level shown while the driver is off
  input wire logic [7:0] idle_level,
  // Comparator outputs
  output logic [3:0] comp_high,
  output logic [3:0] comp_low
);
  logic [1:0] lvl;
  always_comb begin
    lvl = 2'h0;
    for (int c = 0; c < 4; c++) begin
      lvl = drive_on[c] ? {1'b0, drive_level[c]} : idle_level[c*2+:2];
      comp_high[c] = (lvl == 2'h1);
      comp_low[c] = (lvl != 2'h0);
    end
  end
endmodule

// ### bench/pwf_top_tb.sv
// Purpose: Self-checking bench for the pin waveform formatter.
// Assumes: Calibration zero, no multiplex; offset, compare period and round trip last.
// Notes: All channels get the same waveforms, so every fail nibble repeats.
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %0t: got %0h exp %0h", $time, (a), (e)); end end
module pwf_top_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic valid = 1'b0;
  logic [31:0] sel = 32'h0;
  logic tper = 1'b0;
  logic cper = 1'b0;
  logic [7:0] gofs = 8'h00;
  logic [3:0] mask = 4'h0;
  logic [12:0] addr = 13'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] idle_lvl = 8'h00;
  logic [15:0] fail_flags, fire, seen;
  logic [3:0] lvl, on, load, comp_h, comp_l;
  logic [95:0] vern;
  logic [31:0] rdata;
  int num_errors = 0;
  int checks_done = 0;

  always #25 mclk = ~mclk;

  pwf_top uut (
    .MCLK(mclk), .RST(rst), .PATTERN_VALID_QUAL(valid), .WAVEFORM_SELECT(sel),
    .TESTER_PERIOD(tper), .COMPARE_PERIOD(cper), .GLOBAL_EDGE_OFFSET(gofs),
    .FAIL_MASK_IN(mask), .FAIL_FLAGS_OUT(fail_flags), .COMP_HIGH(comp_h), .COMP_LOW(comp_l),
    .PIN_DRIVE_LEVEL(lvl), .PIN_DRIVE_ON(on), .PIN_LOAD_ON(load), .EDGE_FIRE(fire),
    .EDGE_VERNIER(vern), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata)
  );

  pwf_pin_model pins (
    .drive_level(lvl), .drive_on(on), .idle_level(idle_lvl),
    .comp_high(comp_h), .comp_low(comp_l)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [12:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Codes are {slot3, slot2, slot1, slot0}; slots 0 and 2 use zero delay
  task automatic put(input logic [7:0] e, input logic [15:0] c, input logic [21:0] d1, d3);
    for (int ch = 0; ch < 4; ch++)
      for (int s = 0; s < 4; s++)
        wr_reg({1'b0, 2'(ch), e, 2'(s)},
          {6'h00, c[s*4+:4], (s == 1) ? d1 : ((s == 3) ? d3 : 22'h0)});
  endtask

  task automatic period(input logic [7:0] e);
    @(posedge mclk);
    sel <= {4{e}};
    tper <= 1'b1;
    @(posedge mclk);
    tper <= 1'b0;
  endtask

  // Bounded wait for channel 0 edge i; a miss ends the run
  task automatic wait_fire(input int i);
    int n;
    n = 0;
    while (fire[i] !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(fire[i], 1'b1)
    if (fire[i] !== 1'b1) report_and_stop();
  endtask

  // One compare period, then an idle period that carries its flags out
  task automatic cmp_run(input logic [7:0] e, input logic [3:0] exp);
    period(e);
    repeat (10) @(posedge mclk);
    period(8'h01);
    repeat (2) @(posedge mclk);
    #1;
    `CHK(fail_flags, {4{exp}})
  endtask

  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK({fail_flags, lvl, on, load}, 28'h0)
    rd_chk(pwf_pkg::CTRL_OFS, pwf_pkg::CTRL_RST);
    rd_chk(13'h1002, 32'h0);
    for (int k = 0; k < 16; k++)
      wr_reg(pwf_pkg::CAL_OFS + 13'(k), 32'h0);
    // Event codes follow table order: N,0,1,Z,U,D,P,L,H,X,T,V,l,h,t,v
    put(8'h01, 16'h0000, 22'h0, 22'h0);
    put(8'h02, 16'h0014, 22'h061, 22'h0);
    put(8'h03, 16'h0003, 22'h0, 22'h0);
    put(8'h04, 16'h9D78, 22'h0, 22'h040);
    put(8'h05, 16'h9FBA, 22'h0, 22'h040);
    put(8'h06, 16'h9E9C, 22'h040, 22'h040);
    // Force up at the period start, drive low one coarse step later
    @(posedge mclk);
    valid <= 1'b1;
    period(8'h02);
    wait_fire(0);
    `CHK({lvl, on, load}, 12'hFF0)
    wait_fire(1);
    // Vernier 0x21: round(33 * 60 / 64) = 31
    `CHK(vern[11:6], 6'h1F)
    `CHK({lvl, on, load}, 12'h0F0)
    rd_chk(13'h0009, 32'h0040_0061);
    // Qualifier low: a force-off waveform must not reach the pins
    @(posedge mclk);
    valid <= 1'b0;
    period(8'h03);
    seen = 16'h0;
    repeat (12) begin
      @(posedge mclk);
      #1;
      seen = seen | fire;
    end
    `CHK(seen, 16'h0)
    `CHK(on, 4'hF)
    @(posedge mclk);
    valid <= 1'b1;
    // Pin held low by its driver until the offset check forces it up
    cmp_run(8'h04, 4'h9);
    cmp_run(8'h05, 4'h1);
    cmp_run(8'h06, 4'h8);
    for (int c = 0; c < 4; c++)
      rd_chk(pwf_pkg::CNT_OFS + 13'(c), 32'h4);
    rd_chk(pwf_pkg::ACC_OFS, 32'hF);
    wr_reg(pwf_pkg::ACC_OFS, 32'hF);
    rd_chk(pwf_pkg::ACC_OFS, 32'h0);
    // Masked edges still show on the flags but leave count and sticky flag alone
    @(posedge mclk);
    mask <= 4'hF;
    cmp_run(8'h04, 4'h9);
    rd_chk(pwf_pkg::CNT_OFS, 32'h4);
    rd_chk(pwf_pkg::ACC_OFS, 32'h0);
    @(posedge mclk);
    mask <= 4'h0;
    wr_reg(pwf_pkg::CNT_OFS, 32'h0);
    rd_chk(pwf_pkg::CNT_OFS, 32'h0);
    // Edge 0 follows the compare period; round trip of two cycles
    wr_reg(pwf_pkg::CTRL_OFS, 32'h0000_0201);
    rd_chk(pwf_pkg::CTRL_OFS, 32'h0000_0201);
    cmp_run(8'h04, 4'h8);
    // Offset of one coarse step delays the force-up by one cycle
    @(posedge mclk);
    gofs <= 8'h40;
    sel <= {4{8'h02}};
    cper <= 1'b1;
    @(posedge mclk);
    cper <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    `CHK(fire[3:0], 4'h1)
    `CHK(lvl, 4'hF)
    report_and_stop();
  end
endmodule

// ### include/pwf_edge_if.sv
// Purpose: Link between the formatter core and one edge delay generator.
// Assumes: Start is a one-cycle pulse carrying delay and code.
// Notes: Fire outputs are registered inside the generator.
`timescale 1ns/1ns
interface pwf_edge_if;
  logic start;
  logic [23:0] dly;
  logic [3:0] code;
  logic fire;
  logic [3:0] fire_code;
  logic [5:0] fine;
  modport gen (input start, dly, code, output fire, fire_code, fine);
  modport ctl (output start, dly, code, input fire, fire_code, fine);
endinterface

// ### include/pwf_pkg.sv
// Purpose: Shared constants, event codes and helpers for the pin waveform formatter.
// Assumes: One master clock; each coarse delay count is one master clock step.
// Notes: Host address bit 12 selects registers, otherwise waveform memory.
package pwf_pkg;
  localparam int NCH = 4;
  localparam int NEDGE = 4;
  localparam int NEV = 16;
  localparam int WSEL_W = 8;
  localparam int WMEM_DEPTH = 256;
  localparam int SLOT_W = 26;
  localparam int DLY_W = 22;
  localparam int CODE_LSB = 22;
  localparam int GOFS_W = 8;
  localparam int VERN_W = 6;
  localparam int EFF_W = 24;
  localparam int CNT_W = 18;
  localparam int RTD_MAX = 16;
  localparam int RTD_W = 4;
  localparam int ADDR_W = 13;
  localparam int REG_SEL_BIT = 12;
  localparam int MEM_CH_LSB = 10;
  localparam int MEM_ENT_LSB = 2;
  // Timing figures
  localparam int MCLK_PERIOD_PS = 50000;
  localparam int RTD_STEP_PS = 2500;
  localparam int COARSE_STEP_PS = 2500;
  localparam int VERN_RES_FS = 39060;
  localparam int RTD_STEP_CYC = (RTD_STEP_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam logic [11:0] VERN_STEPS = 12'h03C;
  localparam logic [11:0] VERN_HALF = 12'h020;
  // Register offsets
  localparam logic [12:0] CTRL_OFS = 13'h1000;
  localparam logic [12:0] ACC_OFS = 13'h1001;
  localparam logic [12:0] CNT_OFS = 13'h1004;
  localparam logic [12:0] CAL_OFS = 13'h1010;
  localparam int CTRL_PSEL_LSB = 0;
  localparam int CTRL_MUX01_BIT = 4;
  localparam int CTRL_MUX23_BIT = 5;
  localparam int CTRL_RTD_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    EV_NONE = 4'h0, EV_DRV_LOW = 4'h1, EV_DRV_HIGH = 4'h2, EV_FORCE_OFF = 4'h3,
    EV_FORCE_UP = 4'h4, EV_FORCE_DOWN = 4'h5, EV_FORCE_PRIOR = 4'h6, EV_CMP_LOW = 4'h7,
    EV_CMP_HIGH = 4'h8, EV_CMP_DONTCARE = 4'h9, EV_CMP_MID = 4'hA, EV_CMP_VALID = 4'hB,
    EV_WIN_LOW = 4'hC, EV_WIN_HIGH = 4'hD, EV_WIN_MID = 4'hE, EV_WIN_VALID = 4'hF
  } pwf_event_t;

  // Fine step index = INT(0.5 + v*60/64)
  function automatic logic [5:0] vern_map(input logic [5:0] v);
    logic [11:0] p;
    p = {6'h00, v} * VERN_STEPS + VERN_HALF;
    return p[11:6];
  endfunction

  // Level 0 low, 1 high, 2 midband, 3 valid
  function automatic logic [1:0] cmp_level(input logic [3:0] c);
    case (c)
      EV_CMP_HIGH, EV_WIN_HIGH: cmp_level = 2'h1;
      EV_CMP_MID, EV_WIN_MID: cmp_level = 2'h2;
      EV_CMP_VALID, EV_WIN_VALID: cmp_level = 2'h3;
      default: cmp_level = 2'h0;
    endcase
  endfunction

  function automatic logic is_compare(input logic [3:0] c);
    return c >= EV_CMP_LOW;
  endfunction

  function automatic logic level_match(input logic [1:0] lvl, input logic h, input logic l);
    case (lvl)
      2'h0: level_match = !l;
      2'h1: level_match = h;
      2'h2: level_match = l && !h;
      default: level_match = h || !l;
    endcase
  endfunction
endpackage

// ### logic/pwf_edge_gen.sv
// Purpose: One edge delay generator: coarse count down plus mapped vernier.
// Assumes: Delay low six bits are the vernier fraction of one coarse step.
// Notes: A new start replaces a pending edge; only one edge in flight.
`timescale 1ns/1ns
module pwf_edge_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core link
  pwf_edge_if.gen eg
);
  typedef struct packed {
    logic busy;
    logic [17:0] cnt;
    logic [3:0] code;
    logic [5:0] fine;
    logic fire;
    logic [3:0] fire_code;
    logic [5:0] fire_fine;
  } pwf_gen_state_t;

  pwf_gen_state_t q;
  pwf_gen_state_t d;

  always_comb begin
    d = q;
    d.fire = 1'b0;
    if (eg.start) begin
      d.busy = 1'b1;
      d.cnt = eg.dly[23:6];
      d.code = eg.code;
      d.fine = pwf_pkg::vern_map(eg.dly[5:0]);
    end else if (q.busy) begin
      if (q.cnt == 18'h00000) begin
        d.busy = 1'b0;
        d.fire = 1'b1;
        d.fire_code = q.code;
        d.fire_fine = q.fine;
      end else begin
        d.cnt = q.cnt - 18'h00001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign eg.fire = q.fire;
  assign eg.fire_code = q.fire_code;
  assign eg.fine = q.fire_fine;

  a_zero_count_fire: assert property (@(posedge clk) disable iff (rst)
    eg.start && eg.dly[23:6] == 18'h00000 |-> ##2 eg.fire)
    else $error("edge with zero coarse count did not fire two cycles later");
  a_vernier_range: assert property (@(posedge clk) disable iff (rst)
    eg.start ##1 !eg.start [*1] |-> q.fine == pwf_pkg::vern_map($past(eg.dly[5:0])))
    else $error("vernier mapping wrong");
endmodule

// ### logic/pwf_top.sv
// Purpose: Four-channel waveform formatter: memory lookup, edges, drive and compare.
// Assumes: All sequencer and comparator inputs are synchronous to MCLK.
// Notes: One coarse delay count equals one MCLK cycle in this implementation.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module pwf_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Sequencer
  input wire logic PATTERN_VALID_QUAL,
  input wire logic [31:0] WAVEFORM_SELECT,
  input wire logic TESTER_PERIOD,
  input wire logic COMPARE_PERIOD,
  input wire logic [7:0] GLOBAL_EDGE_OFFSET,
  input wire logic [3:0] FAIL_MASK_IN,
  output logic [15:0] FAIL_FLAGS_OUT,
  // Pin electronics
  input wire logic [3:0] COMP_HIGH,
  input wire logic [3:0] COMP_LOW,
  output logic [3:0] PIN_DRIVE_LEVEL,
  output logic [3:0] PIN_DRIVE_ON,
  output logic [3:0] PIN_LOAD_ON,
  output logic [15:0] EDGE_FIRE,
  output logic [95:0] EDGE_VERNIER,
  // Host port
  input wire logic [12:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);
  typedef struct packed {
    logic valid;
    logic t0;
    logic c0;
    logic [3:0][7:0] addr;
    logic [7:0] gofs;
    logic [3:0] mask;
    logic [3:0] comp_h;
    logic [3:0] comp_l;
    logic [31:0] ctrl;
    logic [15:0][21:0] cal;
    logic [15:0][15:0][4:0] pipe;
    logic [3:0][1:0] win_open;
    logic [3:0][1:0][1:0] win_lvl;
    logic [3:0][1:0] win_fail;
    logic [3:0][3:0] pfail;
    logic [15:0] fail_out;
    logic [3:0] acc;
    logic [3:0][31:0] cnt;
    logic [3:0] lvl;
    logic [3:0] on;
    logic [3:0] load;
    logic [15:0] fire;
    logic [15:0][5:0] vern;
    logic [31:0] rdata;
  } pwf_state_t;

  pwf_state_t q;
  pwf_state_t d;

  // 256 entries of four 26-bit slots per channel
  logic [103:0] wmem [pwf_pkg::NCH][pwf_pkg::WMEM_DEPTH];
  logic [3:0][103:0] wrd;
  logic [15:0] fire_w;
  logic [15:0][3:0] code_w;
  logic [15:0][5:0] fine_w;
  logic [15:0][4:0] cur;
  logic [15:0][4:0] tap;
  logic [3:0][3:0] cf;
  logic [3:0] rtd_cyc;
  logic host_mem_wr;

  pwf_edge_if eif [16] ();

  // Not reset: software must load every entry it bursts
  // Host port on one side, pattern lookup on the other
  assign host_mem_wr = WR && !ADDR[pwf_pkg::REG_SEL_BIT];
  always_ff @(posedge MCLK) begin
    if (host_mem_wr) begin
      wmem[ADDR[11:10]][ADDR[9:2]][ADDR[1:0] * 26 +: 26] <= WDATA[25:0];
    end
  end

  genvar gc, ge;
  generate
    for (gc = 0; gc < pwf_pkg::NCH; gc++) begin : g_ch
      assign wrd[gc] = wmem[gc][q.addr[gc]];
      for (ge = 0; ge < pwf_pkg::NEDGE; ge++) begin : g_edge
        localparam int I = gc * 4 + ge;
        logic [3:0] slot_code;
        assign slot_code = wrd[gc][ge * 26 + pwf_pkg::CODE_LSB +: 4];
        // Period source per edge; no start while idle
        assign eif[I].start = q.valid && slot_code != pwf_pkg::EV_NONE &&
          (q.ctrl[pwf_pkg::CTRL_PSEL_LSB + ge] ? q.c0 : q.t0);
        // Three-term sum in vernier units; 24 bits span four periods
        assign eif[I].dly = {2'h0, wrd[gc][ge * 26 +: 22]} + {2'h0, q.cal[slot_code]}
          + {16'h0000, q.gofs};
        assign eif[I].code = slot_code;
        assign fire_w[I] = eif[I].fire;
        assign code_w[I] = eif[I].fire_code;
        assign fine_w[I] = eif[I].fine;
        pwf_edge_gen u_gen (
          .clk(MCLK),
          .rst(RST),
          .eg(eif[I])
        );
      end
    end
  endgenerate

  always_comb begin
    d = q;
    cf = '0;
    d.rdata = 32'h0000_0000;
    d.valid = PATTERN_VALID_QUAL;
    d.t0 = TESTER_PERIOD;
    d.c0 = COMPARE_PERIOD;
    for (int c = 0; c < pwf_pkg::NCH; c++) begin
      if (PATTERN_VALID_QUAL) begin
        d.addr[c] = WAVEFORM_SELECT[c * 8 +: 8];
      end
    end
    d.gofs = GLOBAL_EDGE_OFFSET;
    d.mask = FAIL_MASK_IN;
    d.comp_h = COMP_HIGH;
    d.comp_l = COMP_LOW;
    d.fire = fire_w & {16{q.valid}};
    d.vern = fine_w;
    // Drive flops: adjacent channel first, own edges last so they win
    for (int c = 0; c < pwf_pkg::NCH; c++) begin
      for (int k = 0; k < 2; k++) begin
        int s;
        logic use_src;
        s = (k == 0) ? c - 1 : c;
        use_src = (k == 1) || ((c % 2 == 1) &&
          q.ctrl[(c == 1) ? pwf_pkg::CTRL_MUX01_BIT : pwf_pkg::CTRL_MUX23_BIT]);
        for (int e = 0; e < pwf_pkg::NEDGE; e++) begin
          if (use_src && s >= 0 && fire_w[s * 4 + e] && q.valid) begin
            case (pwf_pkg::pwf_event_t'(code_w[s * 4 + e]))
              pwf_pkg::EV_DRV_LOW: d.lvl[c] = 1'b0;
              pwf_pkg::EV_DRV_HIGH: d.lvl[c] = 1'b1;
              pwf_pkg::EV_FORCE_OFF: begin
                d.on[c] = 1'b0;
                d.load[c] = 1'b1;
              end
              pwf_pkg::EV_FORCE_UP: begin
                d.lvl[c] = 1'b1;
                d.on[c] = 1'b1;
                d.load[c] = 1'b0;
              end
              pwf_pkg::EV_FORCE_DOWN: begin
                d.lvl[c] = 1'b0;
                d.on[c] = 1'b1;
                d.load[c] = 1'b0;
              end
              pwf_pkg::EV_FORCE_PRIOR: d.on[c] = 1'b1;
              default: d.on[c] = d.on[c];
            endcase
          end
        end
      end
    end
    // Round-trip delay on compare events only
    for (int i = 0; i < 16; i++) begin
      cur[i] = {fire_w[i] && q.valid && pwf_pkg::is_compare(code_w[i]), code_w[i]};
    end
    // Four-bit field caps the round trip at fifteen cycles
    rtd_cyc = 4'(q.ctrl[pwf_pkg::CTRL_RTD_LSB +: pwf_pkg::RTD_W] * pwf_pkg::RTD_STEP_CYC);
    d.pipe = {q.pipe[14:0], cur};
    tap = (rtd_cyc == 4'h0) ? cur : q.pipe[rtd_cyc - 4'h1];
    // Compare evaluation
    for (int c = 0; c < pwf_pkg::NCH; c++) begin
      for (int e = 0; e < pwf_pkg::NEDGE; e++) begin
        if (tap[c * 4 + e][4] && tap[c * 4 + e][3:0] inside {pwf_pkg::EV_CMP_LOW,
            pwf_pkg::EV_CMP_HIGH, pwf_pkg::EV_CMP_MID, pwf_pkg::EV_CMP_VALID}) begin
          cf[c][e] = !pwf_pkg::level_match(pwf_pkg::cmp_level(tap[c * 4 + e][3:0]),
            q.comp_h[c], q.comp_l[c]);
        end
      end
      for (int p = 0; p < 2; p++) begin
        logic miss;
        miss = !pwf_pkg::level_match(q.win_lvl[c][p], q.comp_h[c], q.comp_l[c]);
        if (q.win_open[c][p] && miss) begin
          d.win_fail[c][p] = 1'b1;
        end
        // Any compare event on the closing edge, X included, closes the window
        if (tap[c * 4 + 2 * p + 1][4] && q.win_open[c][p]) begin
          cf[c][2 * p + 1] = cf[c][2 * p + 1] || q.win_fail[c][p] || miss;
          d.win_open[c][p] = 1'b0;
          d.win_fail[c][p] = 1'b0;
        end
        if (tap[c * 4 + 2 * p][4] && tap[c * 4 + 2 * p][3:0] >= pwf_pkg::EV_WIN_LOW) begin
          d.win_open[c][p] = 1'b1;
          d.win_lvl[c][p] = pwf_pkg::cmp_level(tap[c * 4 + 2 * p][3:0]);
          d.win_fail[c][p] = 1'b0;
        end
      end
      // A fail in the boundary cycle belongs to the new period
      if (q.t0) begin
        d.fail_out[c * 4 +: 4] = q.pfail[c];
      end
      d.pfail[c] = (q.t0 ? 4'h0 : q.pfail[c]) | cf[c];
    end
    // Host writes
    if (WR && ADDR == pwf_pkg::CTRL_OFS) begin
      d.ctrl = WDATA;
    end
    if (WR && ADDR == pwf_pkg::ACC_OFS) begin
      d.acc = q.acc & ~WDATA[3:0];
    end
    for (int c = 0; c < pwf_pkg::NCH; c++) begin
      logic [3:0] um;
      logic [31:0] inc;
      um = cf[c] & ~q.mask;
      inc = 32'h0000_0000;
      for (int e = 0; e < pwf_pkg::NEDGE; e++) begin
        inc = inc + {31'h0000_0000, um[e]};
      end
      if (WR && ADDR == (pwf_pkg::CNT_OFS | 13'(c))) begin
        d.cnt[c] = 32'h0000_0000;
      end
      // Set wins over a clear in the same cycle
      d.cnt[c] = d.cnt[c] + inc;
      if (|um) begin
        d.acc[c] = 1'b1;
      end
    end
    for (int v = 0; v < pwf_pkg::NEV; v++) begin
      if (WR && ADDR == (pwf_pkg::CAL_OFS | 13'(v))) begin
        d.cal[v] = WDATA[21:0];
      end
    end
    // Host reads, answered next cycle
    if (RD) begin
      if (!ADDR[pwf_pkg::REG_SEL_BIT]) begin
        d.rdata = {6'h00, wmem[ADDR[11:10]][ADDR[9:2]][ADDR[1:0] * 26 +: 26]};
      end else if (ADDR == pwf_pkg::CTRL_OFS) begin
        d.rdata = q.ctrl;
      end else if (ADDR == pwf_pkg::ACC_OFS) begin
        d.rdata = {28'h000_0000, q.acc};
      end else if ((ADDR & 13'h1FFC) == pwf_pkg::CNT_OFS) begin
        d.rdata = q.cnt[ADDR[1:0]];
      end else if ((ADDR & 13'h1FF0) == pwf_pkg::CAL_OFS) begin
        d.rdata = {10'h000, q.cal[ADDR[3:0]]};
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign FAIL_FLAGS_OUT = q.fail_out;
  assign PIN_DRIVE_LEVEL = q.lvl;
  assign PIN_DRIVE_ON = q.on;
  assign PIN_LOAD_ON = q.load;
  assign EDGE_FIRE = q.fire;
  assign EDGE_VERNIER = q.vern;
  assign RDATA = q.rdata;

  // Assertions run on MCLK and sleep through reset
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  a_invalid_hold: assert property (!q.valid |=> $stable(PIN_DRIVE_LEVEL) &&
    $stable(PIN_DRIVE_ON) && EDGE_FIRE == 16'h0000)
    else $error("drive changed while pattern not valid");
  a_period_resync: assert property ($changed(FAIL_FLAGS_OUT) |-> $past(q.t0))
    else $error("fail output moved outside a period start");
  a_mask_count: assert property (q.mask == 4'hF && !WR |=> $stable(q.cnt))
    else $error("masked fail reached a counter");
  // Later edges override earlier ones within one cycle
  a_drive_low: assert property (fire_w[1] && q.valid && fire_w[3:2] == 2'h0 &&
    code_w[1] == pwf_pkg::EV_DRV_LOW |=> !PIN_DRIVE_LEVEL[0])
    else $error("drive low event not applied");
  a_force_up: assert property (fire_w[0] && q.valid && fire_w[3:1] == 3'h0 &&
    code_w[0] == pwf_pkg::EV_FORCE_UP |=> PIN_DRIVE_LEVEL[0] && PIN_DRIVE_ON[0] &&
    !PIN_LOAD_ON[0])
    else $error("force up event not applied");
  a_read_latency: assert property (RD && ADDR == pwf_pkg::ACC_OFS |=>
    RDATA == {28'h000_0000, $past(q.acc)})
    else $error("status read data wrong");
  a_strobe_edge: assert property (tap[2][4] && tap[2][3:0] == pwf_pkg::EV_CMP_HIGH &&
    !q.comp_h[0] |=> q.pfail[0][2])
    else $error("strobe fail not on its own edge");
  a_count_step: assert property (!WR |=> q.cnt[0] - $past(q.cnt[0]) <= 32'h0000_0004)
    else $error("counter stepped by more than four");
  a_select_ignore: assert property (!PATTERN_VALID_QUAL |=> $stable(q.addr))
    else $error("select taken while pattern not valid");
  a_period_source: assert property (eif[0].start |-> q.valid &&
    (q.ctrl[pwf_pkg::CTRL_PSEL_LSB] ? q.c0 : q.t0))
    else $error("edge started off its selected period");
  // The tap must equal the event stream seen two cycles back
  a_rtd_delay: assert property (rtd_cyc == 4'h2 |-> tap == $past(cur, 2))
    else $error("round trip delay tap wrong");
  // Sticky flag and counter both skip masked edges
  a_mask_flag: assert property (q.mask == 4'hF && !WR |=> $stable(q.acc))
    else $error("masked fail set the sticky flag");
  a_window_close: assert property (q.win_open[0][1] && tap[3][4] &&
    !pwf_pkg::level_match(q.win_lvl[0][1], q.comp_h[0], q.comp_l[0]) |=> q.pfail[0][3])
    else $error("window fail not on its closing edge");
  a_vernier_max: assert property (EDGE_VERNIER[5:0] <= 6'h3B)
    else $error("vernier sub-step beyond fifty-nine");

  // Main scenarios
  c_edge_fire: cover property (|EDGE_FIRE);
  c_compare_period: cover property (eif[0].start && q.c0);
  c_rtd_tap: cover property (rtd_cyc != 4'h0 && tap[3][4]);
  c_fail_out: cover property (|FAIL_FLAGS_OUT);
  c_window_close: cover property (q.win_open[0][0] ##1 !q.win_open[0][0]);
endmodule
